// file: inc/csq_pkg.sv
package csq_pkg;
   // Register byte offsets on the Avalon-MM slave.
   localparam logic [5:0] ADDR_GAIN_TWO   = 6'h00;
   localparam logic [5:0] ADDR_GAIN_ONE   = 6'h04;
   localparam logic [5:0] ADDR_RADIO_CFG  = 6'h08;
   localparam logic [5:0] ADDR_PKT_CTRL   = 6'h0C;
   localparam logic [5:0] ADDR_PIN_CFG    = 6'h10;
   localparam logic [5:0] ADDR_PKT_STATUS = 6'h14;
   localparam logic [5:0] ADDR_LINK_QUAL  = 6'h18;
   localparam logic [5:0] ADDR_STROBE     = 6'h1C;

   // Field positions.
   localparam int GOAL_LSB   = 0;
   localparam int DVGA_LSB   = 3;
   localparam int LNA_LSB    = 5;
   localparam int OFFS_LSB   = 0;
   localparam int STEP_LSB   = 4;
   localparam int POLICY_LSB = 0;
   localparam int TRAILER_BIT = 0;
   localparam int STB_TX_BIT  = 0;
   localparam int STB_FS_BIT  = 1;
   localparam int STB_RX_BIT  = 2;
   localparam int STB_IDLE_BIT = 3;

   // Reset values.
   localparam logic [7:0] GAIN_TWO_RST  = 8'h03;
   localparam logic [5:0] GAIN_ONE_RST  = 6'h00;
   localparam logic [1:0] POLICY_RST    = 2'h0;
   localparam logic [5:0] PIN_SEL_RST   = 6'h00;

   // Output pin select codes.
   localparam logic [5:0] PIN_SEL_FREE  = 6'h09;
   localparam logic [5:0] PIN_SEL_SENSE = 6'h0E;

   // Threshold model in half-dB units of the RSSI code.
   localparam logic signed [9:0] THR_BASE_HD  = -10'sd47;
   localparam logic signed [9:0] LNA_STEP_HD  = 10'sd5;
   localparam logic signed [9:0] DVGA_STEP_HD = 10'sd12;
   localparam logic signed [9:0] GOAL_STEP_HD = 10'sd4;
   localparam logic [2:0]        GOAL_REF     = 3'h3;
   localparam logic signed [9:0] HYST_HD      = 10'sd2;
   localparam logic signed [3:0] OFFS_MAX     = 4'sd7;
   localparam logic signed [3:0] OFFS_MIN     = -4'sd7;

   // Relative step codes in half-dB.
   localparam logic [1:0]        STEP_OFF = 2'h0;
   localparam logic signed [9:0] STEP_1_HD = 10'sd12;
   localparam logic signed [9:0] STEP_2_HD = 10'sd20;
   localparam logic signed [9:0] STEP_3_HD = 10'sd28;

   // Channel free policies.
   localparam logic [1:0] POL_ALWAYS = 2'h0;
   localparam logic [1:0] POL_RSSI   = 2'h1;
   localparam logic [1:0] POL_NOPKT  = 2'h2;
   localparam logic [1:0] POL_BOTH   = 2'h3;

   // Link quality window.
   localparam int LQI_SYMBOLS = 64;
   localparam int ERR_W = 7;
   localparam int LQI_W = 7;

   typedef enum logic [3:0]
   {
      CSQ_IDLE = 4'b0001,
      CSQ_RX   = 4'b0010,
      CSQ_TX   = 4'b0100,
      CSQ_FSTX = 4'b1000
   } csq_state_type;
endpackage

// file: inc/csq_lqi_if.sv
`timescale 1ns/1ps
interface csq_lqi_if;
   import csq_pkg::*;
   logic             sync_found;
   logic             sym_valid;
   logic [ERR_W-1:0] err_mag;
   logic [LQI_W-1:0] quality;
   logic             done;

   modport meter
   (
      input  sync_found,
      input  sym_valid,
      input  err_mag,
      output quality,
      output done
   );
   modport user
   (
      output sync_found,
      output sym_valid,
      output err_mag,
      input  quality,
      input  done
   );
endinterface

// file: src/csq_lqi.sv
`timescale 1ns/1ps
module csq_lqi
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Symbol error stream and result.
   csq_lqi_if.meter lq
);
   import csq_pkg::*;

   localparam int CNT_W = $clog2(LQI_SYMBOLS) + 1;
   localparam int ACC_W = ERR_W + $clog2(LQI_SYMBOLS);

   logic [CNT_W-1:0] cnt_q;
   logic [ACC_W-1:0] acc_q;
   logic             busy_q;
   logic [LQI_W-1:0] quality_q;
   logic             done_q;

   // Window of symbols directly after sync; a new sync restarts it.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q  <= '0;
         acc_q  <= '0;
         busy_q <= 1'b0;
      end
      else if (lq.sync_found)
      begin
         cnt_q  <= '0;
         acc_q  <= '0;
         busy_q <= 1'b1;
      end
      else if (busy_q && lq.sym_valid)
      begin
         acc_q <= acc_q + ACC_W'(lq.err_mag);
         cnt_q <= cnt_q + 1'b1;
         if (cnt_q == CNT_W'(LQI_SYMBOLS - 1))
         begin
            busy_q <= 1'b0;
         end
      end
   end

   // Mean error magnitude: a smaller value is a cleaner link.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         quality_q <= '0;
         done_q    <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (busy_q && lq.sym_valid && !lq.sync_found
             && cnt_q == CNT_W'(LQI_SYMBOLS - 1))
         begin
            quality_q <= LQI_W'((acc_q + ACC_W'(lq.err_mag)) >> (ACC_W - LQI_W));
            done_q    <= 1'b1;
         end
      end
   end

   assign lq.quality = quality_q;
   assign lq.done    = done_q;
endmodule

// file: src/csq_top.sv
`timescale 1ns/1ps
// What this block does
// - Offset shifts threshold plus/minus 7 dB, 1 dB steps.
// - Threshold from gain caps, offset and level goal.
// - Offset resets to zero, no shift.
// - Level goal shifts threshold 2 dB per step from code 3.
// - Jump step off, or 6, 10, 14 dB.
// - Jump sense ignores absolute level.
// - Channel free shown on pin at code 0x09.
// - Policy picks one of four free conditions.
// - Transmit strobes in receive need free channel.
// - Rejected strobe never retried; host strobes again.
// - Trailer's last byte carries link quality.
// - Link quality readable in link quality register.
// - Quality averages error over 64 post-sync symbols.
// - Smaller quality value means better link.
// - Level sense uses threshold with hysteresis.
// - Jump sense sets on rise, clears on fall.
// - Sense on pin code 14 and status bit.
module csq_top
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst,
   // Avalon-MM register slave.
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Receive path inputs from the demodulator, plus transmit done.
   input  wire logic [7:0]  rssi,
   input  wire logic        rssi_valid,
   input  wire logic        pkt_active,
   input  wire logic        sync_found,
   input  wire logic        sym_valid,
   input  wire logic [csq_pkg::ERR_W-1:0] sym_err_mag,
   input  wire logic        pkt_end,
   input  wire logic        tx_done,
   // Status trailer byte.
   output logic [7:0]       trailer_byte,
   output logic             trailer_valid,
   // Radio state and output pin.
   output csq_pkg::csq_state_type radio_state,
   output logic             output_pin
);
   import csq_pkg::*;

   logic [7:0]       gain_two_q;
   logic [5:0]       gain_one_q;
   logic [1:0]       policy_q;
   logic             trailer_on_q;
   logic [5:0]       pin_sel_q;
   logic             ack_q;
   logic [31:0]      rdata_q;
   logic             wr_take;
   logic             strobe_tx;
   logic             strobe_fs;
   logic             strobe_rx;
   logic             strobe_idle;
   csq_state_type    state_q;
   logic             abs_cs_q;
   logic             rel_cs_q;
   logic [7:0]       prev_rssi_q;
   logic             prev_ok_q;
   logic             sense;
   logic             chan_free;
   logic signed [9:0] thr_code;
   logic signed [9:0] rssi_s;
   logic signed [9:0] jump;
   logic signed [9:0] step_hd;
   logic [LQI_W-1:0] quality_q;
   logic [7:0]       trailer_q;
   logic             trailer_v_q;
   logic             pin_q;

   csq_lqi_if lq ();

   function automatic logic signed [9:0] step_of(input logic [1:0] code);
      logic signed [9:0] s;
      s = 10'sd0;
      case (code)
         2'h1: s = STEP_1_HD;
         2'h2: s = STEP_2_HD;
         2'h3: s = STEP_3_HD;
         default: s = 10'sd0;
      endcase
      return s;
   endfunction

   function automatic logic signed [3:0] clamp_offs(input logic [3:0] raw);
      logic signed [3:0] v;
      v = $signed(raw);
      if (v < OFFS_MIN)
         v = OFFS_MIN;
      return v;
   endfunction

   // Bus handshake: one wait cycle, answer at the second edge.
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign wr_take         = avs_write && ack_q;
   assign avs_readdata    = rdata_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ack_q <= 1'b0;
      else
         ack_q <= (avs_read || avs_write) && !ack_q;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else if (avs_read && !ack_q)
      begin
         if (avs_address == ADDR_GAIN_TWO)
            rdata_q <= {24'h00_0000, gain_two_q};
         else if (avs_address == ADDR_GAIN_ONE)
            rdata_q <= {26'h000_0000, gain_one_q};
         else if (avs_address == ADDR_RADIO_CFG)
            rdata_q <= {30'h0000_0000, policy_q};
         else if (avs_address == ADDR_PKT_CTRL)
            rdata_q <= {31'h0000_0000, trailer_on_q};
         else if (avs_address == ADDR_PIN_CFG)
            rdata_q <= {26'h000_0000, pin_sel_q};
         else if (avs_address == ADDR_PKT_STATUS)
            rdata_q <= {24'h00_0000, state_q, 1'b0, pkt_active, chan_free, sense};
         else if (avs_address == ADDR_LINK_QUAL)
            rdata_q <= {25'h000_0000, quality_q};
         else
            rdata_q <= 32'h0000_0000;
      end
   end

   // Configuration registers.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gain_two_q   <= GAIN_TWO_RST;
         gain_one_q   <= GAIN_ONE_RST;
         policy_q     <= POLICY_RST;
         trailer_on_q <= 1'b0;
         pin_sel_q    <= PIN_SEL_RST;
      end
      else if (wr_take)
      begin
         if (avs_address == ADDR_GAIN_TWO)
            gain_two_q <= avs_writedata[7:0];
         else if (avs_address == ADDR_GAIN_ONE)
            gain_one_q <= avs_writedata[5:0];
         else if (avs_address == ADDR_RADIO_CFG)
            policy_q <= avs_writedata[POLICY_LSB +: 2];
         else if (avs_address == ADDR_PKT_CTRL)
            trailer_on_q <= avs_writedata[TRAILER_BIT];
         else if (avs_address == ADDR_PIN_CFG)
            pin_sel_q <= avs_writedata[5:0];
      end
   end

   // Command strobes are one-cycle events from the strobe register.
   assign strobe_tx   = wr_take && avs_address == ADDR_STROBE && avs_writedata[STB_TX_BIT];
   assign strobe_fs   = wr_take && avs_address == ADDR_STROBE && avs_writedata[STB_FS_BIT];
   assign strobe_rx   = wr_take && avs_address == ADDR_STROBE && avs_writedata[STB_RX_BIT];
   assign strobe_idle = wr_take && avs_address == ADDR_STROBE && avs_writedata[STB_IDLE_BIT];

   // Absolute threshold in RSSI code units.
   always_comb
   begin
      thr_code = THR_BASE_HD
               + LNA_STEP_HD * $signed({7'h00, gain_two_q[LNA_LSB +: 3]})
               + DVGA_STEP_HD * $signed({8'h00, gain_two_q[DVGA_LSB +: 2]})
               + GOAL_STEP_HD * ($signed({7'h00, gain_two_q[GOAL_LSB +: 3]})
                                 - $signed({7'h00, GOAL_REF}))
               + 10'($signed(clamp_offs(gain_one_q[OFFS_LSB +: 4])) * 2);
   end

   assign rssi_s  = 10'($signed(rssi));
   assign jump    = rssi_s - 10'($signed(prev_rssi_q));
   assign step_hd = step_of(gain_one_q[STEP_LSB +: 2]);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         abs_cs_q <= 1'b0;
      else if (state_q != CSQ_RX)
         abs_cs_q <= 1'b0;
      else if (rssi_valid)
      begin
         if (rssi_s >= thr_code)
            abs_cs_q <= 1'b1;
         else if (rssi_s < thr_code - HYST_HD)
            abs_cs_q <= 1'b0;
      end
   end

   // Jump sense compares consecutive samples only.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rel_cs_q    <= 1'b0;
         prev_rssi_q <= 8'h00;
         prev_ok_q   <= 1'b0;
      end
      else if (state_q != CSQ_RX || gain_one_q[STEP_LSB +: 2] == STEP_OFF)
      begin
         rel_cs_q  <= 1'b0;
         prev_ok_q <= 1'b0;
      end
      else if (rssi_valid)
      begin
         prev_rssi_q <= rssi;
         prev_ok_q   <= 1'b1;
         if (prev_ok_q && jump >= step_hd)
         begin
            rel_cs_q <= 1'b1;
         end
         else if (prev_ok_q && jump <= -step_hd)
         begin
            rel_cs_q <= 1'b0;
         end
      end
   end

   assign sense = abs_cs_q || rel_cs_q;

   always_comb
   begin
      case (policy_q)
         POL_ALWAYS: chan_free = 1'b1;
         POL_RSSI:   chan_free = !sense;
         POL_NOPKT:  chan_free = !pkt_active;
         POL_BOTH:   chan_free = !sense && !pkt_active;
         default:    chan_free = 1'b1;
      endcase
   end

   // Radio state; a refused strobe leaves no pending request.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state_q <= CSQ_IDLE;
      else if (strobe_idle)
         state_q <= CSQ_IDLE;
      else
      begin
         case (state_q)
            CSQ_IDLE:
               if (strobe_tx)
                  state_q <= CSQ_TX;
               else if (strobe_fs)
                  state_q <= CSQ_FSTX;
               else if (strobe_rx)
                  state_q <= CSQ_RX;
            CSQ_RX:
               if (strobe_tx && chan_free)
                  state_q <= CSQ_TX;
               else if (strobe_fs && chan_free)
                  state_q <= CSQ_FSTX;
            CSQ_FSTX:
               if (strobe_tx)
                  state_q <= CSQ_TX;
               else if (strobe_rx)
                  state_q <= CSQ_RX;
            CSQ_TX:
               if (tx_done)
                  state_q <= CSQ_IDLE;
            default:
               state_q <= CSQ_IDLE;
         endcase
      end
   end

   // Link quality meter.
   assign lq.sync_found = sync_found && state_q == CSQ_RX;
   assign lq.sym_valid  = sym_valid;
   assign lq.err_mag    = sym_err_mag;

   csq_lqi u_lqi
   (
      .clk (clk),
      .rst (rst),
      .lq  (lq)
   );

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         quality_q <= '0;
      else if (lq.done)
         quality_q <= lq.quality;
   end

   // Last trailer byte of a received packet.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         trailer_q   <= 8'h00;
         trailer_v_q <= 1'b0;
      end
      else
      begin
         trailer_v_q <= pkt_end && trailer_on_q;
         if (pkt_end && trailer_on_q)
         begin
            trailer_q <= {1'b0, quality_q};
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pin_q <= 1'b0;
      else if (pin_sel_q == PIN_SEL_FREE)
         pin_q <= chan_free;
      else if (pin_sel_q == PIN_SEL_SENSE)
         pin_q <= sense;
      else
         pin_q <= 1'b0;
   end

   assign trailer_byte  = trailer_q;
   assign trailer_valid = trailer_v_q;
   assign radio_state   = state_q;
   assign output_pin    = pin_q;
endmodule

// file: verif/csq_chk.sv
`timescale 1ns/1ps
module csq_chk
(
   // Clock and reset.
   input wire logic                   clk,
   input wire logic                   rst,
   // Register bus.
   input wire logic [5:0]             avs_address,
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic [31:0]            avs_writedata,
   input wire logic [31:0]            avs_readdata,
   input wire logic                   avs_waitrequest,
   // Receive and transmit events and results.
   input wire logic                   pkt_end,
   input wire logic                   tx_done,
   input wire logic [7:0]             trailer_byte,
   input wire logic                   trailer_valid,
   input wire csq_pkg::csq_state_type radio_state
);
   import csq_pkg::*;
   logic strobe_hit;
   assign strobe_hit = avs_write && !avs_waitrequest && avs_address == ADDR_STROBE;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence bus_request;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence strobe_taken;
      strobe_hit;
   endsequence
   sequence packet_closed;
      pkt_end ##1 trailer_valid;
   endsequence

   a_one_wait: assert property (bus_request |=> !avs_waitrequest)
      else $error("waitrequest held beyond one wait cycle");
   a_wait_quiet: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest raised with no request");
   a_read_hold: assert property (!$stable(avs_readdata) |-> $past(avs_read))
      else $error("read data changed without a read");
   a_state_onehot: assert property ($onehot(radio_state))
      else $error("radio state is not one-hot");
   a_idle_wins: assert property (strobe_taken ##0 avs_writedata[STB_IDLE_BIT]
      |=> radio_state == CSQ_IDLE)
      else $error("idle strobe did not reach idle");
   a_rx_enter: assert property (strobe_taken ##0 (avs_writedata[3:0] == 4'h4)
      ##0 (radio_state == CSQ_IDLE) |=> radio_state == CSQ_RX)
      else $error("receive strobe did not reach receive");
   a_no_retry: assert property (radio_state == CSQ_RX && !strobe_hit |=> radio_state == CSQ_RX)
      else $error("receive left without a strobe");
   a_tx_ends: assert property (radio_state == CSQ_TX && tx_done |=> radio_state == CSQ_IDLE)
      else $error("transmit did not end in idle");
   a_trailer_cause: assert property (trailer_valid |-> $past(pkt_end))
      else $error("trailer byte without end of payload");
   a_trailer_once: assert property (packet_closed |=> !trailer_valid)
      else $error("trailer valid longer than one cycle");
   a_trailer_top: assert property (trailer_valid |-> !trailer_byte[7])
      else $error("trailer byte top bit set");
endmodule

bind csq_top csq_chk i_csq_chk
(
   .clk             (clk),
   .rst             (rst),
   .avs_address     (avs_address),
   .avs_read        (avs_read),
   .avs_write       (avs_write),
   .avs_writedata   (avs_writedata),
   .avs_readdata    (avs_readdata),
   .avs_waitrequest (avs_waitrequest),
   .pkt_end         (pkt_end),
   .tx_done         (tx_done),
   .trailer_byte    (trailer_byte),
   .trailer_valid   (trailer_valid),
   .radio_state     (radio_state)
);

// file: verif/csq_host.sv
`timescale 1ns/1ps
module csq_host
(
   // Clock.
   input  wire logic        clk,
   // Avalon-MM master.
   output logic [5:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   import csq_pkg::*;
   initial
   begin
      avs_address   = 6'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0000_0000;
   end

   // Released lines show the inverse so stale values are never mistaken for data.
   task automatic access(input logic [5:0] a, input logic wr, input logic [31:0] wd,
                         output logic [31:0] rd);
      @(posedge clk);
      avs_address   <= a;
      avs_read      <= !wr;
      avs_write     <= wr;
      avs_writedata <= wd;
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read      <= 1'b0;
      avs_write     <= 1'b0;
      avs_address   <= ~a;
      avs_writedata <= ~wd;
   endtask

   task automatic write(input logic [5:0] a, input logic [31:0] wd);
      logic [31:0] d;
      access(a, 1'b1, wd, d);
   endtask

   task automatic read(input logic [5:0] a, output logic [31:0] rd);
      access(a, 1'b0, 32'h0000_0000, rd);
   endtask

   // Each transmit attempt is a fresh strobe; nothing is repeated on its own.
   task automatic strobe(input logic [3:0] cmd);
      write(ADDR_STROBE, {28'h000_0000, cmd});
   endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import csq_pkg::*;
   logic             clk;
   logic             rst;
   logic [5:0]       avs_address;
   logic             avs_read;
   logic             avs_write;
   logic [31:0]      avs_writedata;
   logic [31:0]      avs_readdata;
   logic             avs_waitrequest;
   logic [7:0]       rssi;
   logic             rssi_valid;
   logic             pkt_active;
   logic             sync_found;
   logic             sym_valid;
   logic [ERR_W-1:0] sym_err_mag;
   logic             pkt_end;
   logic             tx_done;
   logic [7:0]       trailer_byte;
   logic             trailer_valid;
   csq_state_type    radio_state;
   logic             output_pin;
   int               mismatches;
   int               checks;
   int               cycles;

   csq_host i_csq_host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   csq_top i_csq_top (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rssi(rssi), .rssi_valid(rssi_valid),
      .pkt_active(pkt_active), .sync_found(sync_found), .sym_valid(sym_valid),
      .sym_err_mag(sym_err_mag), .pkt_end(pkt_end), .tx_done(tx_done),
      .trailer_byte(trailer_byte), .trailer_valid(trailer_valid),
      .radio_state(radio_state), .output_pin(output_pin));

   always #12.5 clk = ~clk;

   task automatic complete_run;
      if (mismatches == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         mismatches++;
         complete_run;
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic sample(input logic [7:0] v);
      @(posedge clk);
      rssi       <= v;
      rssi_valid <= 1'b1;
      @(posedge clk);
      rssi_valid <= 1'b0;
      rssi       <= ~v;
   endtask

   task automatic sense_is(input logic exp);
      logic [31:0] d;
      i_csq_host.read(ADDR_PKT_STATUS, d);
      check("sense bit", 32'(d[0]), 32'(exp));
      check("sense pin", 32'(output_pin), 32'(exp));
   endtask

   function automatic int thr_of(logic [7:0] g, logic [3:0] o);
      int off = int'($signed(o));
      if (off < -7)
         off = -7;
      return -47 + 5 * int'(g[7:5]) + 12 * int'(g[4:3]) + 4 * (int'(g[2:0]) - 3) + 2 * off;
   endfunction

   task automatic test_reset;
      logic [5:0]  a [6] = '{ADDR_GAIN_TWO, ADDR_GAIN_ONE, ADDR_RADIO_CFG, ADDR_PKT_CTRL,
                             ADDR_PIN_CFG, 6'h20};
      logic [31:0] e [6] = '{32'(GAIN_TWO_RST), 32'(GAIN_ONE_RST), 32'(POLICY_RST),
                             32'h0000_0000, 32'(PIN_SEL_RST), 32'h0000_0000};
      logic [31:0] d;
      check("state", 32'(radio_state), 32'(CSQ_IDLE));
      for (int k = 0; k < 6; k++)
      begin
         i_csq_host.read(a[k], d);
         check("reset value", d, e[k]);
      end
   endtask

   task automatic test_level;
      logic [7:0] g [4] = '{8'h03, 8'h03, 8'h4F, 8'h03};
      logic [3:0] o [4] = '{4'h0, 4'h9, 4'h7, 4'h8};
      int         t;
      i_csq_host.write(ADDR_PIN_CFG, 32'(PIN_SEL_SENSE));
      i_csq_host.strobe(4'h4);
      for (int k = 0; k < 4; k++)
      begin
         i_csq_host.write(ADDR_GAIN_TWO, 32'(g[k]));
         i_csq_host.write(ADDR_GAIN_ONE, 32'(o[k]));
         t = thr_of(g[k], o[k]);
         sample(8'(t - 1));
         sense_is(1'b0);
         sample(8'(t));
         sense_is(1'b1);
         sample(8'(t - 2));
         sense_is(1'b1);
         sample(8'(t - 3));
         sense_is(1'b0);
      end
   endtask

   task automatic test_jump;
      int hd;
      i_csq_host.write(ADDR_GAIN_TWO, 32'h0000_00FF);
      for (int st = 0; st < 4; st++)
      begin
         hd = 4 + 8 * st;
         i_csq_host.write(ADDR_GAIN_ONE, 32'(st * 16 + 7));
         sample(8'(-100));
         sample(8'(-100 + hd - 1));
         sense_is(1'b0);
         sample(8'(-100 + 2 * hd - 1));
         sense_is(st != 0);
         sample(8'(-100 + hd));
         sense_is(st != 0);
         sample(8'(-100));
         sense_is(1'b0);
      end
   endtask

   task automatic test_policy;
      logic          free;
      csq_state_type exp_st;
      i_csq_host.write(ADDR_GAIN_TWO, 32'h0000_001F);
      i_csq_host.write(ADDR_GAIN_TWO, 32'h0000_0003);
      i_csq_host.write(ADDR_GAIN_ONE, 32'h0000_0000);
      i_csq_host.write(ADDR_PIN_CFG, 32'(PIN_SEL_FREE));
      for (int p = 0; p < 4; p++)
         for (int c = 0; c < 3; c++)
         begin
            i_csq_host.write(ADDR_RADIO_CFG, 32'(p));
            i_csq_host.strobe(4'h8);
            i_csq_host.strobe(4'h4);
            pkt_active <= (c == 1);
            sample(c == 0 ? 8'h00 : 8'hA0);
            free = (p[0] ? (c != 0) : 1'b1) && (p[1] ? (c != 1) : 1'b1);
            tick(3);
            check("free pin", 32'(output_pin), 32'(free));
            i_csq_host.strobe(c == 2 ? 4'h2 : 4'h1);
            tick(1);
            exp_st = !free ? CSQ_RX : (c == 2 ? CSQ_FSTX : CSQ_TX);
            check("state", 32'(radio_state), 32'(exp_st));
            if (!free)
            begin
               pkt_active <= 1'b0;
               sample(8'hA0);
               tick(3);
               check("state", 32'(radio_state), 32'(CSQ_RX));
            end
            else if (c != 2)
            begin
               @(posedge clk);
               tx_done <= 1'b1;
               @(posedge clk);
               tx_done <= 1'b0;
            end
         end
   endtask

   task automatic test_quality;
      logic [31:0]      d;
      logic [31:0]      prev;
      logic [ERR_W-1:0] err;
      int               sum;
      i_csq_host.write(ADDR_PKT_CTRL, 32'h0000_0001);
      i_csq_host.strobe(4'h8);
      i_csq_host.strobe(4'h4);
      for (int r = 0; r < 2; r++)
      begin
         sum = 0;
         @(posedge clk);
         sync_found <= 1'b1;
         @(posedge clk);
         sync_found <= 1'b0;
         for (int i = 0; i < 65; i++)
         begin
            err = (i == 64) ? 7'h7F : (r == 0 ? 7'(i + 10) : 7'h02);
            if (i < 64)
               sum += int'(err);
            @(posedge clk);
            sym_valid   <= 1'b1;
            sym_err_mag <= err;
            @(posedge clk);
            sym_valid   <= 1'b0;
            sym_err_mag <= ~err;
         end
         tick(2);
         i_csq_host.read(ADDR_LINK_QUAL, d);
         check("quality", d, 32'(sum >> 6));
         if (r == 1)
            check("ordering", 32'(d < prev), 32'h0000_0001);
         prev = d;
         @(posedge clk);
         pkt_end <= 1'b1;
         @(posedge clk);
         pkt_end <= 1'b0;
         @(negedge clk);
         check("trailer", {23'h00_0000, trailer_valid, trailer_byte},
               {23'h00_0000, 1'b1, 1'b0, 7'(sum >> 6)});
      end
   endtask

   initial
   begin
      clk         = 1'b0;
      rst         = 1'b1;
      rssi        = 8'h00;
      rssi_valid  = 1'b0;
      pkt_active  = 1'b0;
      sync_found  = 1'b0;
      sym_valid   = 1'b0;
      sym_err_mag = 7'h00;
      pkt_end     = 1'b0;
      tx_done     = 1'b0;
      mismatches  = 0;
      checks      = 0;
      cycles      = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      test_reset;
      test_level;
      test_jump;
      test_policy;
      test_quality;
      complete_run;
   end
endmodule
